// File: qaoc_pkg.sv
// Shared constants and types for the quad converter output control block
package qaoc_pkg;

  // Data path shape
  localparam int DW       = 11;
  localparam int RAW_W    = 12;
  localparam int NCH      = 4;
  localparam int LATENCY  = 9;
  localparam int DL_DEPTH = LATENCY - 1;

  // Register map (byte addresses, one word each)
  localparam int          AXI_AW     = 8;
  localparam logic [7:0]  ADDR_CTRL  = 8'h00;
  localparam logic [7:0]  ADDR_NSCTL = 8'h04;
  localparam logic [7:0]  ADDR_TUNE  = 8'h08;
  localparam logic [7:0]  ADDR_STAT  = 8'h0C;
  localparam logic [1:0]  IDX_CTRL   = 2'h0;
  localparam logic [1:0]  IDX_NSCTL  = 2'h1;
  localparam logic [1:0]  IDX_TUNE   = 2'h2;
  localparam logic [1:0]  IDX_STAT   = 2'h3;

  // Control register fields
  localparam int CTRL_TWOS    = 0;
  localparam int CTRL_PD      = 1;
  localparam int CTRL_STBY    = 2;
  localparam int CTRL_SYNC_EN = 3;
  localparam int CTRL_LOOP_EN = 4;
  localparam int CTRL_DIV_LSB = 8;
  localparam int CTRL_DIV_MSB = 10;

  // Noise shaper control fields
  localparam int NS_EN_LSB  = 0;
  localparam int NS_IGN_LSB = 4;
  localparam int NS_BW_LSB  = 8;
  localparam int NS_BW_MSB  = 10;
  localparam int TUNE_MSB   = 5;

  // Reset values and writable masks
  localparam logic [31:0] CTRL_RST   = 32'h0000_0010;
  localparam logic [31:0] NSCTL_RST  = 32'h0000_0000;
  localparam logic [31:0] TUNE_RST   = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_071F;
  localparam logic [31:0] NSCTL_MASK = 32'h0000_07FF;
  localparam logic [31:0] TUNE_MASK  = 32'h0000_003F;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam int unsigned SYS_CLK_HZ     = 10_000_000;
  localparam int unsigned LOOP_MIN_HZ    = 40_000_000;
  localparam int unsigned RELOCK_MIN_NS  = 1500;
  localparam int unsigned RELOCK_MAX_NS  = 5000;
  localparam int unsigned RELOCK_CYC     = (RELOCK_MAX_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;

  // About -0.6 dB as a fraction of 256
  localparam int ATT_NUM   = 239;
  localparam int ATT_SHIFT = 8;

  typedef logic [DW-1:0] qaoc_word_t;
  typedef logic [NCH-1:0][RAW_W-1:0] qaoc_raw_t;

  typedef struct packed {
    qaoc_word_t d;
    qaoc_word_t c;
    qaoc_word_t b;
    qaoc_word_t a;
  } qaoc_quad_t;

  typedef enum logic [1:0] {PW_RUN, PW_STBY, PW_OFF} qaoc_pwr_t;

endpackage : qaoc_pkg

// File: qaoc_delay.sv
// Circular word store that delays samples by a fixed number of advances
`timescale 1ns/1ps
module qaoc_delay
  import qaoc_pkg::*;
#(
  parameter int W     = 44,
  parameter int DEPTH = DL_DEPTH
)(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Sample stream
  input  wire logic         adv,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           ptr;
    logic [W-1:0]            q;
  } qaoc_dl_t;

  qaoc_dl_t s_ff;
  qaoc_dl_t nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    if (adv)
    begin
      nxt_s.mem[s_ff.ptr] = din;
      nxt_s.q             = s_ff.mem[s_ff.ptr];
      nxt_s.ptr           = (s_ff.ptr == PW'(DEPTH - 1)) ? '0 : PW'(s_ff.ptr + 1'b1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign dout = s_ff.q;

endmodule : qaoc_delay

// File: qaoc_top.sv
// Output side control of a four channel converter with register access
`timescale 1ns/1ps
module qaoc_top
  import qaoc_pkg::*;
#(
  parameter int unsigned CLK_HZ        = SYS_CLK_HZ,
  parameter int unsigned RELOCK_CYCLES = RELOCK_CYC
)(
  // Clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              RESET,
  // Converter core samples, signed, one bit of headroom
  input  wire qaoc_raw_t         CORE_SAMPLES,
  // Asynchronous control pins
  input  wire logic              POWER_DOWN_REQUEST,
  input  wire logic              PLAIN_MODE,
  input  wire logic              DIV_SYNC,
  // Output lanes
  output logic      [DW-1:0]     LANE0_DATA,
  output logic      [DW-1:0]     LANE1_DATA,
  output logic                   DATA_CAPTURE_STROBE,
  output logic                   DOUT_OE,
  // Status toward analog and shaper
  output logic                   REF_ON,
  output logic                   EDGE_RETIMING_LOOP_BYPASS,
  output logic      [NCH-1:0]    NS_ACTIVE,
  output logic      [2:0]        NS_BW_MODE,
  output logic      [5:0]        NS_TUNE,
  // AXI4-Lite write
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [AXI_AW-1:0] AWADDR,
  input  wire logic [2:0]        AWPROT,
  input  wire logic              WVALID,
  output logic                   WREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  output logic                   BVALID,
  input  wire logic              BREADY,
  output logic      [1:0]        BRESP,
  // AXI4-Lite read
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  input  wire logic [AXI_AW-1:0] ARADDR,
  input  wire logic [2:0]        ARPROT,
  output logic                   RVALID,
  input  wire logic              RREADY,
  output logic      [31:0]       RDATA,
  output logic      [1:0]        RRESP
);

  localparam bit LOOP_FN = (CLK_HZ >= LOOP_MIN_HZ);

  typedef struct packed {
    logic [1:0]        mode_s;
    logic [1:0]        pd_s;
    logic [1:0]        sync_s;
    logic              sync_d;
    logic [31:0]       ctrl;
    logic [31:0]       nsctl;
    logic [31:0]       tune;
    logic              awv;
    logic [AXI_AW-1:0] awa;
    logic              wv;
    logic [31:0]       wd;
    logic [3:0]        ws;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [3:0]        cnt;
    logic [12:0]       relock;
    qaoc_pwr_t         pwr;
    logic              strobe;
    logic              oe;
    qaoc_word_t        lane0;
    qaoc_word_t        lane1;
    qaoc_word_t        bd_b;
    qaoc_word_t        bd_d;
  } qaoc_st_t;

  qaoc_st_t   s_ff;
  qaoc_st_t   nxt_s;
  qaoc_quad_t fmt_q;
  qaoc_quad_t dly_q;
  qaoc_word_t fmt_w [NCH];
  logic [NCH-1:0] ns_act;
  logic [2:0]  wsel;
  logic [2:0]  rsel;
  logic [31:0] stat_w;
  logic [3:0]  half;
  logic [3:0]  per_m1;
  logic        tick;
  logic        sync_edge;
  logic        locked;
  logic        pd_req;
  logic        stby_sel;

  // Address decode: top bit flags an unmapped address
  function automatic logic [2:0] reg_idx(input logic [AXI_AW-1:0] a);
    case (a)
      ADDR_CTRL:  reg_idx = {1'b0, IDX_CTRL};
      ADDR_NSCTL: reg_idx = {1'b0, IDX_NSCTL};
      ADDR_TUNE:  reg_idx = {1'b0, IDX_TUNE};
      ADDR_STAT:  reg_idx = {1'b0, IDX_STAT};
      default:    reg_idx = 3'h4;
    endcase
  endfunction : reg_idx

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] st);
    wmerge = o;
    for (int k = 0; k < 4; k++)
      if (st[k])
        wmerge[8*k +: 8] = d[8*k +: 8];
  endfunction : wmerge

  // Attenuate, saturate and code one converter word
  function automatic qaoc_word_t fmt_word(input logic [RAW_W-1:0] r, input logic ns,
                                          input logic twos);
    logic signed [20:0] m;
    qaoc_word_t         w;
    m = 21'(signed'(r));
    if (ns)
      m = (m * 21'(ATT_NUM)) >>> ATT_SHIFT;
    if (m > 21'sd1023)
      m = 21'sd1023;
    else if (m < -21'sd1024)
      m = -21'sd1024;
    w = m[DW-1:0];
    fmt_word = twos ? w : {~w[DW-1], w[DW-2:0]};
  endfunction : fmt_word

  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    assign ns_act[i] = s_ff.nsctl[NS_IGN_LSB+i] ? s_ff.nsctl[NS_EN_LSB+i]
                                                : ~s_ff.mode_s[1];
    assign fmt_w[i]  = fmt_word(CORE_SAMPLES[i], ns_act[i], s_ff.ctrl[CTRL_TWOS]);
  end

  assign fmt_q     = '{d: fmt_w[3], c: fmt_w[2], b: fmt_w[1], a: fmt_w[0]};
  assign wsel      = reg_idx(s_ff.awa);
  assign rsel      = reg_idx(ARADDR);
  assign half      = 4'({1'b0, s_ff.ctrl[CTRL_DIV_MSB:CTRL_DIV_LSB]} + 4'h1);
  assign per_m1    = 4'((half << 1) - 4'h1);
  assign tick      = (s_ff.cnt == 4'h0) && (s_ff.pwr == PW_RUN);
  assign sync_edge = s_ff.sync_s[1] & ~s_ff.sync_d;
  assign locked    = s_ff.ctrl[CTRL_LOOP_EN] && LOOP_FN && (s_ff.relock == 13'h0);
  assign pd_req    = s_ff.pd_s[1] | s_ff.ctrl[CTRL_PD];
  assign stby_sel  = s_ff.ctrl[CTRL_PD] & s_ff.ctrl[CTRL_STBY] & ~s_ff.pd_s[1];
  assign stat_w    = {24'h00_0000, ns_act, LOOP_FN, locked, REF_ON, s_ff.pwr != PW_RUN};

  qaoc_delay #(
    .W     ($bits(qaoc_quad_t)),
    .DEPTH (DL_DEPTH)
  ) u_delay (
    .clk  (SYS_CLK),
    .rst  (RESET),
    .adv  (tick),
    .din  (fmt_q),
    .dout (dly_q)
  );

  always_comb
  begin
    nxt_s        = s_ff;
    nxt_s.mode_s = {s_ff.mode_s[0], PLAIN_MODE};
    nxt_s.pd_s   = {s_ff.pd_s[0], POWER_DOWN_REQUEST};
    nxt_s.sync_s = {s_ff.sync_s[0], DIV_SYNC};
    nxt_s.sync_d = s_ff.sync_s[1];

    // Write channel: address and data held until both are in
    if (!s_ff.awv && AWVALID)
    begin
      nxt_s.awv = 1'b1;
      nxt_s.awa = AWADDR;
    end
    if (!s_ff.wv && WVALID)
    begin
      nxt_s.wv = 1'b1;
      nxt_s.wd = WDATA;
      nxt_s.ws = WSTRB;
    end
    if (s_ff.bvalid && BREADY)
      nxt_s.bvalid = 1'b0;
    if (s_ff.awv && s_ff.wv && !s_ff.bvalid)
    begin
      nxt_s.awv    = 1'b0;
      nxt_s.wv     = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp  = RESP_OKAY;
      case (wsel)
        {1'b0, IDX_CTRL}:  nxt_s.ctrl  = wmerge(s_ff.ctrl, s_ff.wd, s_ff.ws) & CTRL_MASK;
        {1'b0, IDX_NSCTL}: nxt_s.nsctl = wmerge(s_ff.nsctl, s_ff.wd, s_ff.ws) & NSCTL_MASK;
        {1'b0, IDX_TUNE}:  nxt_s.tune  = wmerge(s_ff.tune, s_ff.wd, s_ff.ws) & TUNE_MASK;
        {1'b0, IDX_STAT}:  nxt_s.bresp = RESP_OKAY;
        default:           nxt_s.bresp = RESP_SLVERR;
      endcase
    end

    // Read channel
    if (s_ff.rvalid && RREADY)
      nxt_s.rvalid = 1'b0;
    if (!s_ff.rvalid && ARVALID)
    begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp  = RESP_OKAY;
      case (rsel)
        {1'b0, IDX_CTRL}:  nxt_s.rdata = s_ff.ctrl;
        {1'b0, IDX_NSCTL}: nxt_s.rdata = s_ff.nsctl;
        {1'b0, IDX_TUNE}:  nxt_s.rdata = s_ff.tune;
        {1'b0, IDX_STAT}:  nxt_s.rdata = stat_w;
        default:
        begin
          nxt_s.rdata = 32'h0000_0000;
          nxt_s.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Rate change or loop enable restarts the relock wait
    if ((nxt_s.ctrl[CTRL_DIV_MSB:CTRL_DIV_LSB] != s_ff.ctrl[CTRL_DIV_MSB:CTRL_DIV_LSB]) ||
        (nxt_s.ctrl[CTRL_LOOP_EN] && !s_ff.ctrl[CTRL_LOOP_EN]))
      nxt_s.relock = 13'(RELOCK_CYCLES);
    else if (s_ff.relock != 13'h0)
      nxt_s.relock = 13'(s_ff.relock - 13'h1);

    // Power state
    case (s_ff.pwr)
      PW_RUN:
        if (pd_req)
          nxt_s.pwr = stby_sel ? PW_STBY : PW_OFF;
      PW_STBY:
        if (!pd_req)
          nxt_s.pwr = PW_RUN;
        else if (!stby_sel)
          nxt_s.pwr = PW_OFF;
      PW_OFF:
        if (!pd_req)
          nxt_s.pwr = PW_RUN;
        else if (stby_sel)
          nxt_s.pwr = PW_STBY;
      default:
        nxt_s.pwr = PW_OFF;
    endcase
    nxt_s.oe = (nxt_s.pwr == PW_RUN);

    // Sample divider, realigned by sync
    if (sync_edge && s_ff.ctrl[CTRL_SYNC_EN])
      nxt_s.cnt = 4'h0;
    else if (s_ff.cnt >= per_m1)
      nxt_s.cnt = 4'h0;
    else
      nxt_s.cnt = 4'(s_ff.cnt + 4'h1);
    nxt_s.strobe = (nxt_s.cnt != 4'h0) && (nxt_s.cnt <= half);

    // Lane interleave on strobe phases
    if (tick)
    begin
      nxt_s.lane0 = dly_q.a;
      nxt_s.lane1 = dly_q.c;
      nxt_s.bd_b  = dly_q.b;
      nxt_s.bd_d  = dly_q.d;
    end
    else if (s_ff.strobe && !nxt_s.strobe)
    begin
      nxt_s.lane0 = s_ff.bd_b;
      nxt_s.lane1 = s_ff.bd_d;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      s_ff       <= '0;
      s_ff.ctrl  <= CTRL_RST;
      s_ff.nsctl <= NSCTL_RST;
      s_ff.tune  <= TUNE_RST;
      s_ff.pwr   <= PW_OFF;
      s_ff.mode_s <= 2'h3;
    end
    else
      s_ff <= nxt_s;
  end

  assign LANE0_DATA          = s_ff.lane0;
  assign LANE1_DATA          = s_ff.lane1;
  assign DATA_CAPTURE_STROBE = s_ff.strobe;
  assign DOUT_OE             = s_ff.oe;
  assign REF_ON              = (s_ff.pwr != PW_OFF);
  assign EDGE_RETIMING_LOOP_BYPASS = ~locked;
  assign NS_ACTIVE           = ns_act;
  assign NS_BW_MODE          = s_ff.nsctl[NS_BW_MSB:NS_BW_LSB];
  assign NS_TUNE             = s_ff.tune[TUNE_MSB:0];
  assign AWREADY             = ~s_ff.awv;
  assign WREADY              = ~s_ff.wv;
  assign BVALID              = s_ff.bvalid;
  assign BRESP               = s_ff.bresp;
  assign ARREADY             = ~s_ff.rvalid;
  assign RVALID              = s_ff.rvalid;
  assign RDATA               = s_ff.rdata;
  assign RRESP               = s_ff.rresp;

  property p_pin_pd;
    @(posedge SYS_CLK) disable iff (RESET) s_ff.pd_s[1] |=> s_ff.pwr == PW_OFF;
  endproperty
  a_pin_pd: assert property (p_pin_pd) else $error("Pin power-down not taken");

  property p_oe_off;
    @(posedge SYS_CLK) disable iff (RESET) s_ff.pwr != PW_RUN |-> !DOUT_OE;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("Outputs driven in power-down");

  property p_wake;
    @(posedge SYS_CLK) disable iff (RESET)
      !RESET && !pd_req ##1 !pd_req |-> s_ff.pwr == PW_RUN && DOUT_OE;
  endproperty
  a_wake: assert property (p_wake) else $error("No return to normal operation");

  property p_sync_div;
    @(posedge SYS_CLK) disable iff (RESET)
      sync_edge && s_ff.ctrl[CTRL_SYNC_EN] |=> s_ff.cnt == 4'h0 && !DATA_CAPTURE_STROBE;
  endproperty
  a_sync_div: assert property (p_sync_div) else $error("Divider not realigned");

  property p_lanes_ac;
    @(posedge SYS_CLK) disable iff (RESET)
      $rose(DATA_CAPTURE_STROBE) && $past(tick) |->
        LANE0_DATA == $past(dly_q.a) && LANE1_DATA == $past(dly_q.c);
  endproperty
  a_lanes_ac: assert property (p_lanes_ac) else $error("Wrong words in high phase");

  property p_lanes_bd;
    @(posedge SYS_CLK) disable iff (RESET)
      $fell(DATA_CAPTURE_STROBE) && !$past(tick) |->
        LANE0_DATA == $past(s_ff.bd_b) && LANE1_DATA == $past(s_ff.bd_d);
  endproperty
  a_lanes_bd: assert property (p_lanes_bd) else $error("Wrong words in low phase");

  property p_slow_clk;
    @(posedge SYS_CLK) disable iff (RESET) !LOOP_FN |-> EDGE_RETIMING_LOOP_BYPASS;
  endproperty
  a_slow_clk: assert property (p_slow_clk) else $error("Loop used below minimum rate");

  property p_relock;
    @(posedge SYS_CLK) disable iff (RESET)
      $changed(s_ff.ctrl[CTRL_DIV_MSB:CTRL_DIV_LSB]) |->
        s_ff.relock == 13'(RELOCK_CYCLES) && EDGE_RETIMING_LOOP_BYPASS;
  endproperty
  a_relock: assert property (p_relock) else $error("Relock wait not restarted");

  property p_mode_pin;
    @(posedge SYS_CLK) disable iff (RESET)
      !s_ff.nsctl[NS_IGN_LSB] |-> NS_ACTIVE[0] == !s_ff.mode_s[1];
  endproperty
  a_mode_pin: assert property (p_mode_pin) else $error("Mode pin not obeyed");

  property p_ignore;
    @(posedge SYS_CLK) disable iff (RESET)
      s_ff.nsctl[NS_IGN_LSB+1] |-> NS_ACTIVE[1] == s_ff.nsctl[NS_EN_LSB+1];
  endproperty
  a_ignore: assert property (p_ignore) else $error("Ignore bit not obeyed");

endmodule : qaoc_top

// File: qaoc_capture.sv
// Capture register model latching the interleaved output lanes
`timescale 1ns/1ps
module qaoc_capture
  import qaoc_pkg::*;
(
  // Clock
  input  wire logic          clk,
  // Pins as seen on the board
  input  wire logic [DW-1:0] lane0,
  input  wire logic [DW-1:0] lane1,
  input  wire logic          strobe,
  // Latched words
  output qaoc_quad_t         cap
);
  // Latch mid phase; released pins latch nothing
  always @(negedge clk)
  begin
    if (strobe === 1'b1)
    begin
      cap.a <= lane0;
      cap.c <= lane1;
    end
    else if (strobe === 1'b0)
    begin
      cap.b <= lane0;
      cap.d <= lane1;
    end
  end
endmodule : qaoc_capture

// File: qaoc_top_bench.sv
// Self-checking bench for the quad converter output control block
`timescale 1ns/1ps
module qaoc_top_bench
  import qaoc_pkg::*;
;
  logic              SYS_CLK = 1'b0;
  logic              RESET = 1'b1;
  qaoc_raw_t         CORE_SAMPLES = '0;
  logic              POWER_DOWN_REQUEST = 1'b0;
  logic              PLAIN_MODE = 1'b1;
  logic              DIV_SYNC = 1'b0;
  logic [DW-1:0]     LANE0_DATA, LANE1_DATA;
  logic              DATA_CAPTURE_STROBE, DOUT_OE, REF_ON;
  logic              EDGE_RETIMING_LOOP_BYPASS;
  logic [NCH-1:0]    NS_ACTIVE;
  logic [2:0]        NS_BW_MODE;
  logic [5:0]        NS_TUNE;
  logic              AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic              ARVALID = 1'b0, RREADY = 1'b0;
  logic [AXI_AW-1:0] AWADDR = '0, ARADDR = '0;
  logic [2:0]        AWPROT = 3'h0, ARPROT = 3'h0;
  logic [31:0]       WDATA = '0;
  logic [3:0]        WSTRB = 4'hF;
  logic              AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0]        BRESP, RRESP, rsp;
  logic [31:0]       RDATA, rd;
  qaoc_quad_t        cap;
  int                fails = 0, checked = 0, n, hi;
  int                gap [2];
  int                vals [5] = '{-2048, -1024, 0, 1023, 2047};
  // Board level view of the released pins
  wire logic [DW-1:0] pad0 = DOUT_OE ? LANE0_DATA : 'z;
  wire logic [DW-1:0] pad1 = DOUT_OE ? LANE1_DATA : 'z;
  wire logic          pads = DOUT_OE ? DATA_CAPTURE_STROBE : 1'bz;

  qaoc_top uut (.*);
  qaoc_capture far_end (.clk(SYS_CLK), .lane0(pad0), .lane1(pad1), .strobe(pads), .cap(cap));

  always #50 SYS_CLK = ~SYS_CLK;

  task automatic give_verdict();
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic limit(input int k);
    if (k >= 60)
    begin
      fails++;
      give_verdict();
    end
  endtask : limit

  // Offset binary or twos complement of a clipped sample
  function automatic qaoc_word_t code(input int v, input logic twos);
    int c;
    c = (v < -1024) ? -1024 : ((v > 1023) ? 1023 : v);
    return twos ? qaoc_word_t'(c) : qaoc_word_t'(c + 1024);
  endfunction : code

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge SYS_CLK);
    k = 0;
    AWADDR  <= a;
    WDATA   <= d;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    do
    begin
      @(posedge SYS_CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      k++;
    end
    while (BVALID !== 1'b1 && k < 60);
    BREADY <= 1'b0;
    r = BRESP;
    limit(k);
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge SYS_CLK);
    k = 0;
    ARADDR  <= a;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    do
    begin
      @(posedge SYS_CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      k++;
    end
    while (RVALID !== 1'b1 && k < 60);
    RREADY <= 1'b0;
    d = RDATA;
    r = RRESP;
    limit(k);
  endtask : axr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    axr(a, rd, rsp);
    chk("read_data", rd, e);
    chk("read_resp", rsp, RESP_OKAY);
  endtask : rdchk

  // Returns mid phase after the next strobe rise; n counts clocks
  task automatic wait_rise(output int k);
    logic p;
    p = 1'b1;
    k = 0;
    hi = 0;
    while (!(p === 1'b0 && pads === 1'b1) && k < 60)
    begin
      p = pads;
      @(negedge SYS_CLK);
      hi += (pads === 1'b1);
      k++;
    end
    limit(k);
  endtask : wait_rise

  task automatic wait_oe(input logic v);
    int k;
    k = 0;
    while (DOUT_OE !== v && k < 12)
    begin
      @(posedge SYS_CLK);
      k++;
    end
    chk("out_enable", DOUT_OE, v);
    if (DOUT_OE !== v) give_verdict();
  endtask : wait_oe

  initial
  begin
    repeat (5) @(posedge SYS_CLK);
    chk("oe_in_reset", DOUT_OE, 1'b0);
    chk("bypass_in_reset", EDGE_RETIMING_LOOP_BYPASS, 1'b1);
    repeat (5) @(posedge SYS_CLK);
    RESET <= 1'b0;
    wait_oe(1'b1);
    // Register reset values, masks, unmapped places
    rdchk(ADDR_CTRL, CTRL_RST);
    rdchk(ADDR_NSCTL, NSCTL_RST);
    rdchk(ADDR_TUNE, TUNE_RST);
    axw(ADDR_TUNE, 32'hFFFF_FFFF, rsp);
    chk("write_resp", rsp, RESP_OKAY);
    rdchk(ADDR_TUNE, TUNE_MASK);
    chk("tune_out", NS_TUNE, 6'h3F);
    axr(8'h10, rd, rsp);
    chk("unmapped_rd", rsp, RESP_SLVERR);
    chk("unmapped_data", rd, 32'h0000_0000);
    axw(8'h14, 32'h0000_FFFF, rsp);
    chk("unmapped_wr", rsp, RESP_SLVERR);
    // Latency in sample periods
    wait_rise(n);
    @(posedge SYS_CLK);
    CORE_SAMPLES[0] <= 12'(-300);
    repeat (9) wait_rise(n);
    chk("lat_old", LANE0_DATA, code(0, 1'b0));
    wait_rise(n);
    chk("lat_new", LANE0_DATA, code(-300, 1'b0));
    // Coding table in both formats, distinct word per channel
    for (int t = 0; t < 2; t++)
    begin
      axw(ADDR_CTRL, CTRL_RST | 32'(t), rsp);
      for (int k = 0; k < 5; k++)
      begin
        @(posedge SYS_CLK);
        for (int i = 0; i < NCH; i++) CORE_SAMPLES[i] <= 12'(vals[(k + i) % 5]);
        repeat (12) wait_rise(n);
        chk("word_a", cap.a, code(vals[k], t[0]));
        chk("word_b", cap.b, code(vals[(k + 1) % 5], t[0]));
        chk("word_c", cap.c, code(vals[(k + 2) % 5], t[0]));
        chk("word_d", cap.d, code(vals[(k + 3) % 5], t[0]));
      end
    end
    // Shaper per channel, ignore bits, mode pin, attenuation
    axw(ADDR_NSCTL, 32'h0000_0231, rsp);
    CORE_SAMPLES[0] <= 12'(1023);
    repeat (12) wait_rise(n);
    chk("ns_pin_high", NS_ACTIVE, 4'b0001);
    chk("ns_bw", NS_BW_MODE, 3'h2);
    chk("atten", cap.a, code(1023 * ATT_NUM >> ATT_SHIFT, 1'b1));
    @(posedge SYS_CLK);
    PLAIN_MODE <= 1'b0;
    repeat (5) @(posedge SYS_CLK);
    chk("ns_pin_low", NS_ACTIVE, 4'b1101);
    rdchk(ADDR_STAT, 32'h0000_00D2);
    PLAIN_MODE <= 1'b1;
    axw(ADDR_NSCTL, 32'h0000_0000, rsp);
    // Divider period and half phases
    for (int d = 1; d < 8; d += 6)
    begin
      axw(ADDR_CTRL, 32'h0000_0018 | (32'(d) << CTRL_DIV_LSB), rsp);
      chk("bypass_slow", EDGE_RETIMING_LOOP_BYPASS, 1'b1);
      wait_rise(n);
      wait_rise(n);
      chk("period", n, 2 * (d + 1));
      chk("high_half", hi, d + 1);
    end
    // Sync pulses at two phases must give one alignment
    for (int k = 0; k < 2; k++)
    begin
      wait_rise(n);
      repeat (k * 3 + 1) @(posedge SYS_CLK);
      DIV_SYNC <= 1'b1;
      repeat (3) @(posedge SYS_CLK);
      DIV_SYNC <= 1'b0;
      repeat (12) @(posedge SYS_CLK);
      wait_rise(n);
      gap[k] = n;
    end
    chk("sync_align", gap[0], gap[1]);
    axw(ADDR_CTRL, CTRL_RST, rsp);
    // Power-down from pin, software, standby
    @(posedge SYS_CLK);
    POWER_DOWN_REQUEST <= 1'b1;
    wait_oe(1'b0);
    chk("ref_pin", REF_ON, 1'b0);
    POWER_DOWN_REQUEST <= 1'b0;
    wait_oe(1'b1);
    axw(ADDR_CTRL, 32'h0000_0012, rsp);
    wait_oe(1'b0);
    rdchk(ADDR_STAT, 32'h0000_0001);
    axw(ADDR_CTRL, 32'h0000_0016, rsp);
    repeat (4) @(posedge SYS_CLK);
    chk("ref_stby", REF_ON, 1'b1);
    chk("oe_stby", DOUT_OE, 1'b0);
    POWER_DOWN_REQUEST <= 1'b1;
    repeat (5) @(posedge SYS_CLK);
    chk("ref_both", REF_ON, 1'b0);
    POWER_DOWN_REQUEST <= 1'b0;
    repeat (5) @(posedge SYS_CLK);
    chk("oe_sw_held", DOUT_OE, 1'b0);
    axw(ADDR_CTRL, CTRL_RST, rsp);
    wait_oe(1'b1);
    give_verdict();
  end
endmodule : qaoc_top_bench
